// *** hdl/hwmu_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------------
// Shared constants and types of the half-word multiply unit
// ----------------------------------------------------------------------
package hwmu_pkg;

   // Data path widths
   localparam int unsigned HWMU_WORD_W = 32;
   localparam int unsigned HWMU_HALF_W = 16;
   localparam int unsigned HWMU_PROD_W = 48;
   // One extra bit on each operand so that signed and unsigned share one multiplier
   localparam int unsigned HWMU_OPA_W = HWMU_WORD_W + 1;
   localparam int unsigned HWMU_OPB_W = HWMU_HALF_W + 1;
   localparam int unsigned HWMU_MUL_W = HWMU_OPA_W + HWMU_OPB_W;

   // Field positions inside a source word
   localparam int unsigned HWMU_LO_LSB = 0;
   localparam int unsigned HWMU_LO_MSB = HWMU_HALF_W - 1;
   localparam int unsigned HWMU_UP_LSB = HWMU_HALF_W;
   localparam int unsigned HWMU_UP_MSB = HWMU_WORD_W - 1;
   // Field of the 48-bit product that the high-result operation returns
   localparam int unsigned HWMU_HI_LSB = HWMU_WORD_W;
   localparam int unsigned HWMU_HI_MSB = HWMU_PROD_W - 1;

   // General register index width and the return link register index
   localparam int unsigned HWMU_REG_IDX_W = 6;
   localparam logic [5:0] HWMU_LINK_IDX_DEF = 6'h3f;

   // Bundles between issue and result, counted at one bundle per clock
   localparam int unsigned HWMU_LATENCY = 2;
   // Clock period, ns
   localparam int unsigned HWMU_CLK_PERIOD_NS = 10;

   // Reset values
   localparam logic [31:0] HWMU_DATA_RST = 32'h0000_0000;
   localparam logic [5:0] HWMU_IDX_RST = 6'h00;

   // Operation selector
   typedef enum logic [2:0] {
      HWMU_OP_WORD_BY_UPPER_U,
      HWMU_OP_WORD_BY_LOWER_S,
      HWMU_OP_HALF_BY_UPPER_S,
      HWMU_OP_HALF_BY_UPPER_U,
      HWMU_OP_WORD_BY_LOWER_HIGH,
      HWMU_OP_HALF_BY_HALF_S,
      HWMU_OP_HALF_BY_HALF_U
   } hwmu_op_t;

   // State of the multiplier core
   typedef struct packed {
      logic [HWMU_MUL_W-1:0] product;
   } hwmu_core_state_t;

   // State of the top module
   typedef struct packed {
      logic s1_valid;
      logic s1_drop;
      logic s1_high;
      logic [HWMU_REG_IDX_W-1:0] s1_dest;
      logic wb_valid;
      logic [HWMU_REG_IDX_W-1:0] wb_dest;
      logic [HWMU_WORD_W-1:0] wb_data;
      logic reject;
      logic hazard;
   } hwmu_state_t;

endpackage : hwmu_pkg
`default_nettype wire

// *** hdl/hwmu_mult_core.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Registered signed multiplier, first bundle of the pipeline
// ----------------------------------------------------------------------
module hwmu_mult_core
   import hwmu_pkg::*;
#(
   parameter int unsigned A_W = HWMU_OPA_W,
   parameter int unsigned B_W = HWMU_OPB_W
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic signed [A_W-1:0] opa_i,
   input wire logic signed [B_W-1:0] opb_i,
   output logic [A_W+B_W-1:0] product_o
);

   typedef struct packed {
      logic [A_W+B_W-1:0] product;
   } hwmu_mstate_t;

   hwmu_mstate_t state_reg;
   hwmu_mstate_t state_next;

   // Both operands arrive already extended, so one signed product serves every variant
   always_comb begin
      state_next = state_reg;
      state_next.product = opa_i * opb_i;
   end

   // Product register; reset value is a plain constant
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign product_o = state_reg.product;

endmodule // hwmu_mult_core
`default_nettype wire

// *** hdl/hwmu_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Half-word multiply unit: operand shaping, two-bundle pipeline, write-back
// ----------------------------------------------------------------------
// How it works
// - Word-by-upper unsigned: zero-extended word times zero-extended upper half of operand two.
// - Word-by-half signed: sign-extended word times sign-extended low half of operand two.
// - Half-by-upper signed: sign-extended low half of source one times signed upper half.
// - Half-by-upper unsigned: zero-extended low half times zero-extended upper half.
// - High-result variant forms 48-bit product, returns bits 47..32 sign-extended to 32.
// - High-result variant: source one sign-extended, low half of operand two zero-extended.
// - Half-by-half signed: both low halves sign-extended, product written to destination.
// - Half-by-half unsigned: both low halves zero-extended, product written to destination.
// - Immediate form uses the immediate as operand two and the immediate-form destination.
// - Result arrives two bundles after issue; issuer waits two bundles before reading.
module hwmu_top
   import hwmu_pkg::*;
#(
   parameter logic [HWMU_REG_IDX_W-1:0] LINK_IDX = HWMU_LINK_IDX_DEF
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic issue_valid_i,
   input wire hwmu_op_t op_i,
   input wire logic imm_form_i,
   input wire logic bundle_odd_i,
   input wire logic [HWMU_WORD_W-1:0] src1_i,
   input wire logic [HWMU_WORD_W-1:0] src2_i,
   input wire logic [HWMU_WORD_W-1:0] immediate_second_operand_i,
   input wire logic [HWMU_REG_IDX_W-1:0] dest_i,
   input wire logic [HWMU_REG_IDX_W-1:0] immediate_form_destination_i,
   input wire logic rd_valid_a_i,
   input wire logic [HWMU_REG_IDX_W-1:0] rd_idx_a_i,
   input wire logic rd_valid_b_i,
   input wire logic [HWMU_REG_IDX_W-1:0] rd_idx_b_i,
   output logic wb_valid_o,
   output logic [HWMU_REG_IDX_W-1:0] wb_dest_o,
   output logic [HWMU_WORD_W-1:0] wb_data_o,
   output logic reject_o,
   output logic hazard_o
);

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------

   // Operations that take the upper half of operand two as multiplier
   function automatic logic uses_upper(input hwmu_op_t op);
      case (op)
         HWMU_OP_WORD_BY_UPPER_U,
         HWMU_OP_HALF_BY_UPPER_S,
         HWMU_OP_HALF_BY_UPPER_U: uses_upper = 1'b1;
         default: uses_upper = 1'b0;
      endcase
   endfunction

   // Operations whose first operand is only the low half of source one
   function automatic logic uses_half_a(input hwmu_op_t op);
      case (op)
         HWMU_OP_HALF_BY_UPPER_S,
         HWMU_OP_HALF_BY_UPPER_U,
         HWMU_OP_HALF_BY_HALF_S,
         HWMU_OP_HALF_BY_HALF_U: uses_half_a = 1'b1;
         default: uses_half_a = 1'b0;
      endcase
   endfunction

   // Sign treatment of operand one
   function automatic logic signed_a(input hwmu_op_t op);
      case (op)
         HWMU_OP_WORD_BY_LOWER_S,
         HWMU_OP_HALF_BY_UPPER_S,
         HWMU_OP_WORD_BY_LOWER_HIGH,
         HWMU_OP_HALF_BY_HALF_S: signed_a = 1'b1;
         default: signed_a = 1'b0;
      endcase
   endfunction

   // Sign treatment of operand two; the high-result variant zero-extends it
   function automatic logic signed_b(input hwmu_op_t op);
      case (op)
         HWMU_OP_WORD_BY_LOWER_S,
         HWMU_OP_HALF_BY_UPPER_S,
         HWMU_OP_HALF_BY_HALF_S: signed_b = 1'b1;
         default: signed_b = 1'b0;
      endcase
   endfunction

   // Only one variant returns the high part of the product
   function automatic logic high_result(input hwmu_op_t op);
      high_result = (op == HWMU_OP_WORD_BY_LOWER_HIGH);
   endfunction

   // Index matches an issue one or two bundles old; refused issues count, they are still in flight
   function automatic logic hits_in_flight(input logic [HWMU_REG_IDX_W-1:0] idx, input hwmu_state_t st);
      hits_in_flight = (st.s1_valid && (idx == st.s1_dest))
                       || ((st.wb_valid || st.reject) && (idx == st.wb_dest));
   endfunction

   // Extend a half-word to operand-B width, signed or unsigned
   function automatic logic [HWMU_OPB_W-1:0] ext_half_b(input logic [HWMU_HALF_W-1:0] h, input logic sgn);
      ext_half_b = {sgn & h[HWMU_HALF_W-1], h};
   endfunction

   // Extend a word to operand-A width, signed or unsigned
   function automatic logic [HWMU_OPA_W-1:0] ext_word_a(input logic [HWMU_WORD_W-1:0] w, input logic sgn);
      ext_word_a = {sgn & w[HWMU_WORD_W-1], w};
   endfunction

   // ----------------------------------------------------------------------
   // Operand shaping
   // ----------------------------------------------------------------------

   logic [HWMU_WORD_W-1:0] operand_two;
   logic [HWMU_REG_IDX_W-1:0] issue_dest;
   logic [HWMU_HALF_W-1:0] a_half;
   logic [HWMU_HALF_W-1:0] b_half;
   logic [HWMU_WORD_W-1:0] a_word;
   logic [HWMU_OPA_W-1:0] opa;
   logic [HWMU_OPB_W-1:0] opb;
   logic [HWMU_MUL_W-1:0] product;

   // Immediate form swaps in the immediate and its own destination field
   assign operand_two = imm_form_i ? immediate_second_operand_i : src2_i;
   assign issue_dest = imm_form_i ? immediate_form_destination_i : dest_i;

   // Pick the half of operand two that acts as multiplier
   assign b_half = uses_upper(op_i) ? operand_two[HWMU_UP_MSB:HWMU_UP_LSB]
                                    : operand_two[HWMU_LO_MSB:HWMU_LO_LSB];

   // Low half of source one for the half-word variants
   assign a_half = src1_i[HWMU_LO_MSB:HWMU_LO_LSB];

   // Half-word first operands are widened to a word before the final extension
   assign a_word = uses_half_a(op_i)
                   ? {{HWMU_HALF_W{signed_a(op_i) & a_half[HWMU_HALF_W-1]}}, a_half}
                   : src1_i;

   // One extra bit keeps unsigned values positive inside a signed multiplier
   assign opa = ext_word_a(a_word, signed_a(op_i));
   assign opb = ext_half_b(b_half, signed_b(op_i));

   // ----------------------------------------------------------------------
   // First bundle: registered product
   // ----------------------------------------------------------------------

   hwmu_mult_core #(
      .A_W(HWMU_OPA_W),
      .B_W(HWMU_OPB_W)
   ) u_core (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .opa_i(opa),
      .opb_i(opb),
      .product_o(product)
   );

   // ----------------------------------------------------------------------
   // Result formation
   // ----------------------------------------------------------------------

   // Pipeline state, declared here because result and issue checks read it
   hwmu_state_t state_reg;
   hwmu_state_t state_next;

   logic [HWMU_WORD_W-1:0] res_low;
   logic [HWMU_WORD_W-1:0] res_high;
   logic [HWMU_WORD_W-1:0] result;

   // Truncation to the destination width, upper product bits dropped
   assign res_low = product[HWMU_WORD_W-1:0];
   // A 32 by 16 product fits 48 bits, so bit 47 carries its sign
   assign res_high = {{HWMU_HALF_W{product[HWMU_HI_MSB]}}, product[HWMU_HI_MSB:HWMU_HI_LSB]};
   assign result = state_reg.s1_high ? res_high : res_low;

   // ----------------------------------------------------------------------
   // Issue checks
   // ----------------------------------------------------------------------

   logic issue_bad;
   logic read_a_hit;
   logic read_b_hit;

   // Refuse an issue the issuer should never make: link destination or even slot
   assign issue_bad = (issue_dest == LINK_IDX)
                      || !bundle_odd_i;

   // A read of a destination still in flight breaks the two-bundle wait
   assign read_a_hit = rd_valid_a_i && hits_in_flight(rd_idx_a_i, state_reg);
   assign read_b_hit = rd_valid_b_i && hits_in_flight(rd_idx_b_i, state_reg);

   // ----------------------------------------------------------------------
   // Pipeline state
   // ----------------------------------------------------------------------

   // Dropped issues still walk the pipe so the refusal lines up with the write slot
   always_comb begin
      state_next = state_reg;
      // Stage one: capture control beside the registered product
      state_next.s1_valid = issue_valid_i;
      state_next.s1_drop = issue_valid_i & issue_bad;
      state_next.s1_high = high_result(op_i);
      state_next.s1_dest = issue_dest;
      // Stage two: write-back, second bundle after issue
      state_next.wb_valid = state_reg.s1_valid & ~state_reg.s1_drop;
      state_next.wb_dest = state_reg.s1_dest;
      state_next.wb_data = result;
      state_next.reject = state_reg.s1_valid & state_reg.s1_drop;
      // Hazard reported one cycle after the offending read
      state_next.hazard = read_a_hit | read_b_hit;
   end

   // Single state register; asynchronous reset to constants only
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg.s1_valid <= 1'b0;
         state_reg.s1_drop <= 1'b0;
         state_reg.s1_high <= 1'b0;
         state_reg.s1_dest <= HWMU_IDX_RST;
         state_reg.wb_valid <= 1'b0;
         state_reg.wb_dest <= HWMU_IDX_RST;
         state_reg.wb_data <= HWMU_DATA_RST;
         state_reg.reject <= 1'b0;
         state_reg.hazard <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, each straight from the state register
   // ----------------------------------------------------------------------

   assign wb_valid_o = state_reg.wb_valid;
   assign wb_dest_o = state_reg.wb_dest;
   assign wb_data_o = state_reg.wb_data;
   assign reject_o = state_reg.reject;
   assign hazard_o = state_reg.hazard;

endmodule // hwmu_top
`default_nettype wire

// *** verification/hwmu_chk_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker of the multiply unit
// ----------------------------------------
module hwmu_chk
   import hwmu_pkg::*;
#(
   parameter logic [HWMU_REG_IDX_W-1:0] LINK_IDX = HWMU_LINK_IDX_DEF
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic issue_valid_i,
   input wire hwmu_op_t op_i,
   input wire logic imm_form_i,
   input wire logic bundle_odd_i,
   input wire logic [31:0] src1_i,
   input wire logic [31:0] src2_i,
   input wire logic [31:0] immediate_second_operand_i,
   input wire logic [5:0] dest_i,
   input wire logic [5:0] immediate_form_destination_i,
   input wire logic rd_valid_a_i,
   input wire logic [5:0] rd_idx_a_i,
   input wire logic rd_valid_b_i,
   input wire logic [5:0] rd_idx_b_i,
   input wire logic wb_valid_o,
   input wire logic [5:0] wb_dest_o,
   input wire logic [31:0] wb_data_o,
   input wire logic reject_o,
   input wire logic hazard_o
);
   logic [5:0] dsel;
   logic [31:0] opb;
   logic [31:0] prod_uu;
   logic [31:0] prod_ss;
   logic rd_any;
   // Operands as the issue form selects them
   assign dsel = imm_form_i ? immediate_form_destination_i : dest_i;
   assign opb = imm_form_i ? immediate_second_operand_i : src2_i;
   assign prod_uu = {16'h0, src1_i[15:0]} * {16'h0, opb[15:0]};
   assign prod_ss = $signed(src1_i[15:0]) * $signed(opb[15:0]);
   assign rd_any = rd_valid_a_i || rd_valid_b_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_accept;
      issue_valid_i && bundle_odd_i && dsel != LINK_IDX;
   endsequence
   sequence s_refuse;
      issue_valid_i && (!bundle_odd_i || dsel == LINK_IDX);
   endsequence
   chk_wb_latency: assert property (s_accept |-> ##2 wb_valid_o && !reject_o)
      else $error("write-back missing");
   chk_wb_dest: assert property (s_accept |-> ##2 wb_dest_o == $past(dsel, 2))
      else $error("write-back destination wrong");
   chk_refuse_issue: assert property (s_refuse |-> ##2 reject_o && !wb_valid_o)
      else $error("bad issue not refused");
   chk_wb_cause: assert property (wb_valid_o |-> $past(issue_valid_i, 2))
      else $error("write-back without issue");
   chk_half_u: assert property (s_accept ##0 op_i == HWMU_OP_HALF_BY_HALF_U
      |-> ##2 wb_data_o == $past(prod_uu, 2))
      else $error("unsigned half product wrong");
   chk_half_s: assert property (s_accept ##0 op_i == HWMU_OP_HALF_BY_HALF_S
      |-> ##2 wb_data_o == $past(prod_ss, 2))
      else $error("signed half product wrong");
   chk_high_sign: assert property (s_accept ##0 op_i == HWMU_OP_WORD_BY_LOWER_HIGH
      |-> ##2 wb_data_o[31:16] == {16{wb_data_o[15]}})
      else $error("high result not sign extended");
   chk_hazard_a: assert property (rd_valid_a_i && $past(issue_valid_i) && rd_idx_a_i == $past(dsel) |=> hazard_o)
      else $error("early read not flagged");
   chk_hazard_late: assert property (rd_valid_b_i && $past(issue_valid_i, 2)
      && rd_idx_b_i == $past(dsel, 2) |=> hazard_o)
      else $error("late read not flagged");
   chk_hazard_cause: assert property (hazard_o |-> $past(rd_any))
      else $error("hazard without read");
endmodule // hwmu_chk

bind hwmu_top hwmu_chk #(.LINK_IDX(LINK_IDX)) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .issue_valid_i(issue_valid_i), .op_i(op_i), .imm_form_i(imm_form_i), .bundle_odd_i(bundle_odd_i),
   .src1_i(src1_i), .src2_i(src2_i), .immediate_second_operand_i(immediate_second_operand_i),
   .dest_i(dest_i), .immediate_form_destination_i(immediate_form_destination_i),
   .rd_valid_a_i(rd_valid_a_i), .rd_idx_a_i(rd_idx_a_i), .rd_valid_b_i(rd_valid_b_i), .rd_idx_b_i(rd_idx_b_i),
   .wb_valid_o(wb_valid_o), .wb_dest_o(wb_dest_o), .wb_data_o(wb_data_o), .reject_o(reject_o),
   .hazard_o(hazard_o));
`default_nettype wire

// *** verification/hwmu_rf_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Register file on the far side; takes every write-back pulse
module hwmu_rf_model (
   input wire logic clk_i,
   input wire logic wb_valid_i,
   input wire logic [5:0] wb_dest_i,
   input wire logic [31:0] wb_data_i
);
   logic [31:0] regs [64];
   // One write per clock edge that sees the write-back valid high; back-to-back issues hold it for several cycles
   always @(posedge clk_i) begin
      if (wb_valid_i) regs[wb_dest_i] <= wb_data_i;
   end
endmodule // hwmu_rf_model
`default_nettype wire

// *** verification/half_word_multiply_unit_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module half_word_multiply_unit_test;
   import hwmu_pkg::*;
   typedef struct {logic v; logic [2:0] op; logic imm, odd; logic [31:0] a, b; logic [5:0] d; logic [1:0] rd;
      logic [5:0] ia;} hwmu_item_t;
   logic clk_i = 0, arst_n_i = 0, iv = 0, imm = 0, odd = 0, rva = 0, rvb = 0;
   hwmu_op_t op = HWMU_OP_WORD_BY_UPPER_U;
   logic [31:0] s1 = 0, s2 = 0, im = 0, wbdat;
   logic [5:0] d = 0, id = 0, ria = 0, rib = 0, wbd;
   logic wbv, rej, haz;
   int num_errors = 0, tests_run = 0, cyc = 0;
   hwmu_item_t q[$];
   hwmu_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .issue_valid_i(iv), .op_i(op), .imm_form_i(imm),
      .bundle_odd_i(odd), .src1_i(s1), .src2_i(s2), .immediate_second_operand_i(im), .dest_i(d),
      .immediate_form_destination_i(id), .rd_valid_a_i(rva), .rd_idx_a_i(ria), .rd_valid_b_i(rvb),
      .rd_idx_b_i(rib), .wb_valid_o(wbv), .wb_dest_o(wbd), .wb_data_o(wbdat), .reject_o(rej), .hazard_o(haz));
   hwmu_rf_model rf (.clk_i(clk_i), .wb_valid_i(wbv), .wb_dest_i(wbd), .wb_data_i(wbdat));
   // Reference arithmetic, 64-bit so nothing overflows
   function automatic logic [31:0] exp_res(logic [2:0] o, logic [31:0] a, logic [31:0] b);
      longint p;
      case (o)
         3'h0: p = longint'({32'h0, a}) * longint'({48'h0, b[31:16]});
         3'h1: p = longint'(signed'(a)) * longint'(signed'(b[15:0]));
         3'h2: p = longint'(signed'(a[15:0])) * longint'(signed'(b[31:16]));
         3'h3: p = longint'({48'h0, a[15:0]}) * longint'({48'h0, b[31:16]});
         3'h4: p = longint'(signed'(a)) * longint'({48'h0, b[15:0]});
         3'h5: p = longint'(signed'(a[15:0])) * longint'(signed'(b[15:0]));
         default: p = longint'({48'h0, a[15:0]}) * longint'({48'h0, b[15:0]});
      endcase
      return (o == 3'h4) ? {{16{p[47]}}, p[47:32]} : p[31:0];
   endfunction
   function automatic hwmu_item_t mk(logic v, logic [2:0] o, logic i, logic od, logic [31:0] a, logic [31:0] b,
      logic [5:0] dd, logic [1:0] rd, logic [5:0] ia);
      return '{v, o, i, od, a, b, dd, rd, ia};
   endfunction
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Streams the queue back to back; results are judged two cycles on
   task automatic run_stream();
      hwmu_item_t p, r;
      logic acc, hit;
      for (int i = 0; i < q.size() + 2; i++) begin
         @(negedge clk_i);
         if (i >= 2) begin
            p = q[i-2];
            acc = p.v && p.odd && p.d != HWMU_LINK_IDX_DEF;
            check(wbv, acc);
            check(rej, p.v && !acc);
            if (acc) check(wbd, p.d);
            if (acc) check(wbdat, exp_res(p.op, p.a, p.b));
         end
         if (i >= 1 && i <= q.size()) begin
            r = q[i-1];
            hit = r.rd != 0 && ((i >= 2 && q[i-2].v && q[i-2].d == r.ia) || (i >= 3 && q[i-3].v && q[i-3].d == r.ia));
            check(haz, hit);
         end
         if (i < q.size()) begin
            p = q[i];
            {iv, imm, odd, s1} = {p.v, p.imm, p.odd, p.a};
            op = hwmu_op_t'(p.op);
            s2 = p.imm ? ~p.b : p.b;
            im = p.imm ? p.b : ~p.b;
            d = p.imm ? ~p.d : p.d;
            id = p.imm ? p.d : ~p.d;
            {rva, rvb, ria, rib} = {p.rd[0], p.rd[1], p.ia, p.ia};
         end else {iv, rva, rvb} = 3'h0;
      end
      q.delete();
   endtask
   // Every operation in both forms, sign boundaries in the operands
   task automatic test_arith();
      logic [31:0] av [3] = '{32'h8000_0001, 32'hffff_fffe, 32'h1234_5678};
      logic [31:0] bv [3] = '{32'h8001_ffff, 32'h7fff_8000, 32'hfedc_ba98};
      for (int o = 0; o < 7; o++)
         for (int k = 0; k < 3; k++) q.push_back(mk(1, 3'(o), k[0], 1, av[k], bv[k], 6'(o * 3 + k + 1), 0, 0));
      run_stream();
      // The far-side register file takes the last write one edge later
      @(negedge clk_i);
      check(rf.regs[21], exp_res(3'h6, av[2], bv[2]));
      $display("test_arith done");
   endtask
   // Link destination in both forms and an even slot, then a good issue
   task automatic test_refuse();
      q.push_back(mk(1, 3'h1, 0, 1, 32'h5, 32'h7, 6'h3f, 0, 0));
      q.push_back(mk(1, 3'h5, 1, 1, 32'h5, 32'h7, 6'h3f, 0, 0));
      q.push_back(mk(1, 3'h0, 0, 0, 32'h5, 32'h7_0000, 6'h2, 0, 0));
      q.push_back(mk(1, 3'h4, 0, 1, 32'hffff_ffff, 32'hffff, 6'h3e, 0, 0));
      run_stream();
      $display("test_refuse done");
   endtask
   // Reads one and two cycles after issue, one too late, refused in flight
   task automatic test_hazard();
      q.push_back(mk(1, 3'h6, 0, 1, 32'h3, 32'h4, 6'h5, 0, 0));
      q.push_back(mk(0, 3'h0, 0, 1, 0, 0, 0, 2'h1, 6'h5));
      q.push_back(mk(0, 3'h0, 0, 1, 0, 0, 0, 2'h2, 6'h5));
      q.push_back(mk(0, 3'h0, 0, 1, 0, 0, 0, 2'h1, 6'h5));
      q.push_back(mk(1, 3'h2, 0, 0, 32'h3, 32'h4, 6'h7, 0, 0));
      q.push_back(mk(0, 3'h0, 0, 1, 0, 0, 0, 2'h3, 6'h7));
      q.push_back(mk(0, 3'h0, 0, 1, 0, 0, 0, 2'h2, 6'h7));
      run_stream();
      $display("test_hazard done");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Hang guard, far above the roughly 45 cycles of the run
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         final_report();
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      arst_n_i = 1;
      test_arith();
      test_refuse();
      test_hazard();
      final_report();
   end
endmodule // half_word_multiply_unit_test
`default_nettype wire
